// file: inc/tec_pkg.sv
package tec_pkg;
  // ===========================================
  // Timing
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_NS;
  localparam logic [9:0] EOC_MS_MIN = 10'h001;
  localparam logic [9:0] EOC_MS_MAX = 10'h064;
  localparam logic [13:0] DLY_MS_MAX = 14'h270F;
  // ===========================================
  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_EOCW = 8'h04;
  localparam logic [7:0] OFF_DLY = 8'h08;
  localparam logic [7:0] OFF_GPO = 8'h0C;
  localparam logic [7:0] OFF_EDGE = 8'h10;
  localparam logic [7:0] OFF_CMD = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_RES = 8'h1C;
  // ===========================================
  // Command, status and edge bits
  localparam int unsigned CMD_ARM = 0;
  localparam int unsigned CMD_SWTRIG = 1;
  localparam int unsigned CMD_READ = 2;
  localparam int unsigned CMD_SYSRST = 3;
  localparam int unsigned CMD_LOCAL = 4;
  localparam int unsigned STAT_ERR = 5;
  localparam int unsigned EDGE_TRIGGER_TERMINAL = 0;
  // ===========================================
  // Types and reset values
  typedef struct packed {
    logic autorange;
    logic term_crlf;
    logic delay_en;
    logic eoc_pulse;
    logic src_ext;
    logic cont;
  } tec_ctrl_t;
  localparam tec_ctrl_t CTRL_RST = '{autorange: 1'b0, term_crlf: 1'b0,
    delay_en: 1'b0, eoc_pulse: 1'b0, src_ext: 1'b0, cont: 1'b1};
  localparam logic [9:0] EOCW_RST = 10'h00A;
  localparam logic [13:0] DLY_RST = 14'h0000;
  localparam logic [9:0] GPO_RST = 10'h000;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DELAY, ST_MEAS} tec_state_t;
endpackage : tec_pkg

// file: src/tec_trigger_ctrl.sv
`timescale 1ns/10ps
module tec_trigger_ctrl import tec_pkg::*; #(
  parameter int unsigned CYC_MS = CYC_PER_MS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [4:0] edge_input_line_n,
  input wire logic trigger_terminal_key,
  input wire logic meas_done,
  input wire logic [31:0] meas_result,
  output logic meas_start,
  output logic meas_autorange,
  output logic eoc,
  output logic [9:0] general_output_line,
  output logic term_crlf
);
  // ===========================================
  // Bus phase tracking
  tec_ctrl_t ctrl;
  tec_state_t state;
  logic [9:0] eoc_ms, eoc_cnt;
  logic [13:0] dly_ms, dly_cnt;
  logic [4:0] edges, sync1, sync2, sync3, fall;
  logic [31:0] result;
  logic exec_err, read_pend, remote, d_valid, d_write, addr_ph, wr_commit, cmd_wr, ms_tick;
  logic [7:0] d_off, a_off;
  logic cmd_arm, cmd_sw, cmd_read, cmd_rst, cmd_local, arm_ok, trigger_terminal_fire, start_now, edge_rd;
  logic [$clog2(CYC_MS)-1:0] tick_cnt;
  assign addr_ph = hsel & htrans[1] & hready;
  assign a_off = haddr[7:0];
  assign wr_commit = d_valid & d_write & hreadyout;
  assign cmd_wr = wr_commit & (d_off == OFF_CMD);
  assign cmd_arm = cmd_wr & hwdata[CMD_ARM];
  assign cmd_sw = cmd_wr & hwdata[CMD_SWTRIG];
  assign cmd_read = cmd_wr & hwdata[CMD_READ];
  assign cmd_rst = cmd_wr & hwdata[CMD_SYSRST];
  assign cmd_local = cmd_wr & hwdata[CMD_LOCAL];
  assign edge_rd = addr_ph & ~hwrite & (a_off == OFF_EDGE);

  always_ff @(posedge clk) begin
    if (srst) begin
      d_valid <= 1'b0;
      d_write <= 1'b0;
      d_off <= 8'h00;
    end else if (hreadyout) begin
      d_valid <= addr_ph & (hsize == 3'h2);
      d_write <= hwrite;
      d_off <= a_off;
    end
  end

  // stall commands
  // A command arriving behind a read query waits here until the measurement ends
  always_ff @(posedge clk) begin
    if (srst) begin
      hreadyout <= 1'b1;
    end else if (hreadyout) begin
      hreadyout <= ~(addr_ph & hwrite & (a_off == OFF_CMD) & (read_pend | (cmd_read & ~ctrl.cont)));
    end else begin
      hreadyout <= ~read_pend;
    end
  end
  always_ff @(posedge clk) begin
    hresp <= 1'b0;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ph & ~hwrite) begin
      unique case (a_off)
        OFF_CTRL: hrdata <= {26'h0, ctrl};
        OFF_EOCW: hrdata <= {22'h0, eoc_ms};
        OFF_DLY: hrdata <= {18'h0, dly_ms};
        OFF_GPO: hrdata <= {22'h0, general_output_line};
        OFF_EDGE: hrdata <= {27'h0, edges};
        OFF_STAT: hrdata <= {25'h0, remote, exec_err, read_pend, eoc, 1'h0, state};
        OFF_RES: hrdata <= result;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end
  // ===========================================
  // Settings
  // system reset
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= CTRL_RST;
      eoc_ms <= EOCW_RST;
      dly_ms <= DLY_RST;
      general_output_line <= GPO_RST;
    end else if (cmd_rst) begin
      ctrl <= '{autorange: CTRL_RST.autorange, term_crlf: ctrl.term_crlf, delay_en: CTRL_RST.delay_en,
        eoc_pulse: CTRL_RST.eoc_pulse, src_ext: CTRL_RST.src_ext, cont: CTRL_RST.cont};
      eoc_ms <= EOCW_RST;
      dly_ms <= DLY_RST;
      general_output_line <= GPO_RST;
    end else if (cmd_local) begin
      ctrl.cont <= 1'b1;
    end else if (wr_commit) begin
      unique case (d_off)
        OFF_CTRL: ctrl <= hwdata[5:0];
        OFF_EOCW: eoc_ms <= (hwdata[9:0] < EOC_MS_MIN) ? EOC_MS_MIN :
          (hwdata[9:0] > EOC_MS_MAX) ? EOC_MS_MAX : hwdata[9:0];
        OFF_DLY: dly_ms <= (hwdata[13:0] > DLY_MS_MAX) ? DLY_MS_MAX : hwdata[13:0];
        OFF_GPO: general_output_line <= hwdata[9:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    term_crlf <= srst ? CTRL_RST.term_crlf : ctrl.term_crlf;
  end

  // Any host write puts the block in remote; only the local command leaves it
  always_ff @(posedge clk) begin
    if (srst) begin
      remote <= 1'b0;
    end else if (cmd_local) begin
      remote <= 1'b0;
    end else if (wr_commit) begin
      remote <= 1'b1;
    end
  end

  // ===========================================
  // Edge inputs
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1 <= 5'h1F;
      sync2 <= 5'h1F;
      sync3 <= 5'h1F;
    end else begin
      sync1 <= edge_input_line_n;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  assign fall = sync3 & ~sync2;

  // key and command
  // A new edge in the reading cycle survives the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      edges <= 5'h00;
    end else begin
      edges <= (edge_rd ? 5'h00 : edges) | fall | {4'h0, trigger_terminal_key | cmd_sw};
    end
  end
  // ===========================================
  // Trigger sequencer
  assign arm_ok = (cmd_arm | cmd_read) & ~ctrl.cont;
  assign trigger_terminal_fire = ctrl.src_ext ? (fall[EDGE_TRIGGER_TERMINAL] | trigger_terminal_key | (cmd_sw & ~read_pend)) : 1'b1;
  assign start_now = ((state == ST_WAIT) & trigger_terminal_fire & ~(ctrl.delay_en & (dly_ms != 14'h0))) |
    ((state == ST_DELAY) & ms_tick & (dly_cnt == dly_ms));

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: if (arm_ok | ctrl.cont) begin
          state <= ST_WAIT;
        end
        ST_WAIT: if (start_now) begin
          state <= ST_MEAS;
        end else if (trigger_terminal_fire) begin
          state <= ST_DELAY;
        end
        ST_DELAY: if (start_now) begin
          state <= ST_MEAS;
        end
        ST_MEAS: if (meas_done) begin
          state <= ctrl.cont ? ST_WAIT : ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    meas_start <= ~srst & start_now;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      exec_err <= 1'b0;
    end else if ((cmd_arm | cmd_read) & ctrl.cont) begin
      exec_err <= 1'b1;
    end else if (wr_commit & (d_off == OFF_STAT) & hwdata[STAT_ERR]) begin
      exec_err <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      read_pend <= 1'b0;
      meas_autorange <= 1'b0;
    end else begin
      if (cmd_read & ~ctrl.cont) begin
        read_pend <= 1'b1;
      end else if ((state == ST_MEAS) & meas_done) begin
        read_pend <= 1'b0;
      end
      meas_autorange <= ctrl.autorange & read_pend;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      result <= 32'h0000_0000;
    end else if ((state == ST_MEAS) & meas_done) begin
      result <= meas_result;
    end
  end

  // ===========================================
  // Millisecond timing
  // Free-running tick; counting one extra tick makes every wait at least its figure
  always_ff @(posedge clk) begin
    if (srst) begin
      tick_cnt <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (tick_cnt == ($clog2(CYC_MS))'(CYC_MS - 1));
      tick_cnt <= (tick_cnt == ($clog2(CYC_MS))'(CYC_MS - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dly_cnt <= 14'h0;
    end else if (state != ST_DELAY) begin
      dly_cnt <= 14'h0;
    end else if (ms_tick) begin
      dly_cnt <= dly_cnt + 14'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      eoc <= 1'b0;
      eoc_cnt <= 10'h0;
    end else if ((state == ST_MEAS) & meas_done) begin
      eoc <= 1'b1;
      eoc_cnt <= 10'h0;
    end else if (start_now) begin
      eoc <= 1'b0;
    end else if (eoc & ctrl.eoc_pulse & ms_tick) begin
      eoc_cnt <= eoc_cnt + 10'h1;
      // Compare by size so a width lowered mid-pulse still ends it
      if (eoc_cnt >= eoc_ms) begin
        eoc <= 1'b0;
      end
    end
  end
  // ===========================================
  // Checks
  // Age counts pulse-mode time only; a hold-mode level may last any time
  logic [31:0] eoc_age;
  always_ff @(posedge clk) begin
    if (srst | ~eoc | ~ctrl.eoc_pulse | meas_done) begin
      eoc_age <= 32'h0;
    end else begin
      eoc_age <= eoc_age + 32'h1;
    end
  end
  property p_eoc_set;
    @(posedge clk) disable iff (srst) (state == ST_MEAS) && meas_done |=> eoc;
  endproperty
  a_eoc_set: assert property (p_eoc_set) else $error("done not set");
  property p_eoc_hold;
    @(posedge clk) disable iff (srst) eoc && !ctrl.eoc_pulse && !start_now |=> eoc;
  endproperty
  a_eoc_hold: assert property (p_eoc_hold) else $error("hold done dropped");
  property p_eoc_pulse;
    @(posedge clk) disable iff (srst) ctrl.eoc_pulse && eoc |-> eoc_age <= (32'(eoc_ms) + 32'h2) * CYC_MS;
  endproperty
  a_eoc_pulse: assert property (p_eoc_pulse) else $error("pulse too long");
  property p_gpo;
    @(posedge clk) disable iff (srst) wr_commit && d_off == OFF_GPO && !cmd_rst
      |=> general_output_line == $past(hwdata[9:0]);
  endproperty
  a_gpo: assert property (p_gpo) else $error("outputs wrong");
  property p_edge_clr;
    @(posedge clk) disable iff (srst) edge_rd && fall == 5'h0 && !trigger_terminal_key && !cmd_sw |=> edges == 5'h0;
  endproperty
  a_edge_clr: assert property (p_edge_clr) else $error("edges not cleared");
  property p_idle;
    @(posedge clk) disable iff (srst) state == ST_IDLE && !ctrl.cont && !arm_ok |=> state == ST_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("idle left");
  property p_after_meas;
    @(posedge clk) disable iff (srst) state == ST_MEAS && meas_done
      |=> state == ($past(ctrl.cont) ? ST_WAIT : ST_IDLE);
  endproperty
  a_after_meas: assert property (p_after_meas) else $error("wrong state after");
  property p_free_run;
    @(posedge clk) disable iff (srst) state == ST_WAIT && !ctrl.src_ext && !ctrl.delay_en |=> meas_start;
  endproperty
  a_free_run: assert property (p_free_run) else $error("no free run");
  property p_arm_err;
    @(posedge clk) disable iff (srst) (cmd_arm || cmd_read) && ctrl.cont |=> exec_err ##1 exec_err;
  endproperty
  a_arm_err: assert property (p_arm_err) else $error("error not flagged");
  property p_local;
    @(posedge clk) disable iff (srst) cmd_local && !cmd_rst |=> ctrl.cont && !remote;
  endproperty
  a_local: assert property (p_local) else $error("local kept single");
  property p_stall;
    @(posedge clk) disable iff (srst) !hreadyout |-> read_pend || $past(read_pend);
  endproperty
  a_stall: assert property (p_stall) else $error("stall without read");
endmodule : tec_trigger_ctrl

// file: tb/tb_trigger_and_eoc_control.sv
`timescale 1ns/10ps
module tb_trigger_and_eoc_control;
  import tec_pkg::*;
  // ==========================================
  // Signals
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic trigger_terminal_key = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [4:0] edge_input_line_n = 5'h1F;
  logic [3:0] lat = 4'h2;
  logic hreadyout, hresp, meas_start, meas_autorange, eoc, term_crlf, meas_done;
  logic [31:0] hrdata, meas_result, rd, v;
  logic [9:0] general_output_line;
  int errors = 0;
  int cmp_count = 0;
  int seed = 28;
  int ndone = 0;
  int n;
  int m;
  time t0, t1;

  always #20 clk = ~clk;
  always @(posedge clk) if (meas_done === 1'b1) ndone <= ndone + 1;

  tec_trigger_ctrl #(.CYC_MS(4)) u_tec_trigger_ctrl (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .edge_input_line_n(edge_input_line_n), .trigger_terminal_key(trigger_terminal_key), .meas_done(meas_done),
    .meas_result(meas_result), .meas_start(meas_start), .meas_autorange(meas_autorange), .eoc(eoc),
    .general_output_line(general_output_line), .term_crlf(term_crlf));
  tec_meas_model u_tec_meas_model (.clk(clk), .srst(srst), .meas_start(meas_start), .lat(lat),
    .meas_done(meas_done), .meas_result(meas_result));

  // ==========================================
  // Checks and expectations
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      errors++;
      $display("MISMATCH t=%0t got=%h range=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng
  function automatic logic [31:0] clamp(input logic [31:0] x, input logic [31:0] lo, input logic [31:0] hi);
    return (x < lo) ? lo : ((x > hi) ? hi : x);
  endfunction : clamp
  function automatic logic sv(input int k);
    return (k == 0) ? (meas_start === 1'b1) : ((k == 1) ? (eoc === 1'b0) : (eoc === 1'b1));
  endfunction : sv
  task automatic finish_test();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // ==========================================
  // Bus and pin drivers
  // Ready is a register, so its level at the falling edge is what the next rising edge samples
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(negedge clk); while (hreadyout !== 1'b1);
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    @(negedge clk);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task automatic st(input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, OFF_STAT, 32'h0);
    chk(rd & mask, exp);
  endtask : st
  task automatic key();
    @(posedge clk);
    trigger_terminal_key <= 1'b1;
    @(posedge clk);
    trigger_terminal_key <= 1'b0;
  endtask : key
  task automatic pins(input logic [4:0] low);
    @(posedge clk);
    edge_input_line_n <= ~low;
    @(posedge clk);
    edge_input_line_n <= 5'h1F;
  endtask : pins
  // Returns lim+1 when the event never came
  task automatic wsig(input int k, input int lim, output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (c < lim && !sv(k));
    if (!sv(k)) c = lim + 1;
  endtask : wsig

  // ==========================================
  // Scenarios
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rdc(OFF_CTRL, 32'h1);
    rdc(OFF_EOCW, 32'hA);
    rdc(OFF_DLY, 32'h0);
    rdc(8'h40, 32'h0);
    chk(hresp, 1'b0);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'h0 : ((i == 1) ? 32'hC8 : ($random(seed) & 32'hFF));
      wr(OFF_EOCW, v);
      rdc(OFF_EOCW, clamp(v, 32'h1, 32'h64));
      v = (i == 1) ? 32'h3FFF : ($random(seed) & 32'h3FFF);
      wr(OFF_DLY, v);
      rdc(OFF_DLY, clamp(v, 32'h0, 32'h270F));
      v = (i == 0) ? 32'h3FF : $random(seed);
      wr(OFF_GPO, v);
      chk(general_output_line, v[9:0]);
      lat <= 4'($random(seed));
    end
    wr(OFF_CTRL, 32'h11);
    @(negedge clk);
    chk(term_crlf, 1'b1);
    wsig(0, 60, n);
    wsig(0, 60, n);
    chk_rng(n, 1, 25);
    wr(OFF_CMD, 32'h1);
    st(32'h20, 32'h20);
    wr(OFF_STAT, 32'h20);
    wr(OFF_CMD, 32'h4);
    st(32'h20, 32'h20);
    wr(OFF_STAT, 32'h20);
    st(32'h20, 32'h0);
    wr(OFF_CTRL, 32'h03);
    @(negedge clk);
    chk(term_crlf, 1'b0);
    repeat (60) @(negedge clk);
    chk(eoc, 1'b1);
    st(32'h3, 32'h1);
    key();
    wsig(0, 6, n);
    chk_rng(n, 1, 6);
    wsig(1, 2, n);
    chk_rng(n, 1, 2);
    wsig(2, 30, n);
    chk_rng(n, 1, 30);
    pins(5'h01);
    wsig(0, 12, n);
    chk_rng(n, 1, 8);
    wsig(2, 30, n);
    chk_rng(n, 1, 30);
    wr(OFF_CMD, 32'h2);
    chk(meas_start, 1'b1);
    rdc(OFF_EDGE, 32'h1);
    rdc(OFF_EDGE, 32'h0);
    repeat (3) begin
      v = $random(seed) & 32'h1E;
      pins(v[4:0]);
      repeat (6) @(negedge clk);
      rdc(OFF_EDGE, v);
    end
    wr(OFF_CTRL, 32'h02);
    key();
    repeat (30) @(negedge clk);
    st(32'h3, 32'h0);
    key();
    wsig(0, 20, n);
    chk_rng(n, 21, 21);
    rdc(OFF_EDGE, 32'h1);
    wr(OFF_CMD, 32'h1);
    st(32'h3, 32'h1);
    key();
    repeat (30) @(negedge clk);
    lat <= 4'h8;
    wr(OFF_CTRL, 32'h22);
    wr(OFF_CMD, 32'h4);
    st(32'h13, 32'h11);
    fork
      begin
        t0 = $time;
        wr(OFF_CMD, 32'h2);
        t1 = $time;
      end
      begin
        repeat (10) @(posedge clk);
        key();
        wsig(0, 5, m);
        chk(meas_autorange, 1'b1);
      end
    join
    chk_rng(int'((t1 - t0) / 40), 18, 40);
    wsig(0, 20, n);
    chk_rng(n, 21, 21);
    v = 32'h5A000000 + ndone;
    rdc(OFF_RES, v);
    rdc(OFF_RES, v);
    st(32'h3, 32'h0);
    wr(OFF_EOCW, 32'h2);
    wr(OFF_DLY, 32'h3);
    wr(OFF_CTRL, 32'h0F);
    repeat (4) @(negedge clk);
    key();
    wsig(0, 30, n);
    chk_rng(n, 11, 19);
    wsig(2, 20, n);
    wsig(1, 30, n);
    chk_rng(n, 8, 13);
    wr(OFF_CTRL, 32'h12);
    wr(OFF_CMD, 32'h10);
    rdc(OFF_CTRL, 32'h13);
    st(32'h40, 32'h0);
    wr(OFF_GPO, 32'h155);
    wr(OFF_CMD, 32'h8);
    rdc(OFF_CTRL, 32'h11);
    rdc(OFF_EOCW, 32'hA);
    chk(general_output_line, 10'h000);
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule : tb_trigger_and_eoc_control

// file: tb/tec_meas_model.sv
`timescale 1ns/10ps
module tec_meas_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic meas_start,
  input wire logic [3:0] lat,
  output logic meas_done,
  output logic [31:0] meas_result
);
  // ==========================================
  // Measurement engine with a settable latency
  logic busy;
  logic [3:0] cnt;
  logic [31:0] seq;
  always_ff @(posedge clk) begin
    if (srst) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      meas_done <= 1'b0;
      seq <= 32'h5A000000;
      meas_result <= 32'h00000000;
    end else begin
      meas_done <= 1'b0;
      // Result is only valid with the done pulse, so it toggles elsewhere
      meas_result <= ~meas_result;
      if (meas_start) begin
        busy <= 1'b1;
        cnt <= lat;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        meas_done <= 1'b1;
        seq <= seq + 32'h1;
        meas_result <= seq + 32'h1;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : tec_meas_model
